// File: hdl/upc_pkg.sv
// package for the ulpi phy interface control block
package upc_pkg;
    localparam logic [1:0] CLS_IDLE = 2'h0;
    localparam logic [1:0] CLS_XMIT = 2'h1;
    localparam logic [1:0] CLS_REGW = 2'h2;
    localparam logic [1:0] CLS_REGR = 2'h3;
    localparam logic [5:0] EXT_ADDR_CODE = 6'h2f;
    localparam logic [5:0] NOPID_CODE = 6'h00;
    localparam logic [1:0] PID_HI_ZERO = 2'h0;
    localparam logic [7:0] BUS_IDLE = 8'h00;
    localparam logic [2:0] RST_RELEASE_CYC = 3'h4;
    localparam int REL_W = 3;
    localparam logic [7:0] UPDATE_VBUS_VALID_MASK = 8'h08;
    localparam int A_VLD_BIT = 3;

    typedef struct packed {
        logic alt_int;
        logic id_level;
        logic [1:0] rx_event;
        logic [1:0] vbus_state;
        logic [1:0] line_state;
    } upc_rxcmd_t;

    typedef struct packed {
        logic [7:0] data;
        logic data_oe;
        logic dir;
        logic nxt;
    } upc_ulpi_out_t;

    typedef enum logic [2:0] {
        ST_STARTUP = 3'h0,
        ST_WAIT_RESET = 3'h1,
        ST_IDLE = 3'h3,
        ST_TURN_IN = 3'h2,
        ST_RXCMD = 3'h6,
        ST_TURN_OUT = 3'h7,
        ST_CMD_DATA = 3'h5,
        ST_HW_RELEASE = 3'h4
    } upc_state_t;
endpackage

// File: hdl/upc_ulpi_ctrl.sv
// ulpi side control logic of a usb otg transceiver
// Operation
// - after pll lock, drive clock and drop dir from high to low
// - after power-up release hold dir low until link sends reset command
// - weak pull-up on stp; stp high enables pull-downs on data lines
// - protection disable bit set to one turns the protection off
// - while hardware reset low, assert dir and reset all logic; here only the sequencer state, release count, last rxcmd and need_next reset
// - dir drops four to five cycles after reset release, chip select low
// - chip select high tri-states data, nxt, dir and ignores stp except for low-power exit
// - chip select high still honours stp to leave serial or suspend
// - chip select high drops pull-downs, idles controller, ignores commands
// - chip select high at power-up leaves pll off, else pll stays on
// - pump on when internal bit and not external; external drives switch low
// - fault input watched only when indicator use and passthrough bits set
// - fault shown in a-session vbus valid field; change sends rxcmd
// - device asserts nxt to accept command; link sends following bytes
// - top two command bits select idle, transmit, write or read
// - all-zero transmit payload sends pid-less signalling after next byte
// - transmit payload with upper bits zero carries the pid in low bits
// - payload 101111b takes an 8-bit address next, else 6-bit address
// - any change of rxcmd fields asserts dir and sends an rxcmd
// - rxcmd may be skipped when condition vanished before low-power exit
// - rxcmd carries linestate, vbus, rx event, id and alt bits
// - while dir asserted, nxt low and rxcmd on data bus; here the bus is driven for one cycle per rxcmd, after a free turn cycle
`timescale 1ns/1ps
module upc_ulpi_ctrl
    import upc_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    // ulpi pins, asynchronous to sys_clk_in
    input wire logic hw_reset_n_in,
    input wire logic chip_select_n_in,
    input wire logic stp_in,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe_out,
    output logic dir_out,
    output logic dir_oe_out,
    output logic nxt_out,
    output logic nxt_oe_out,
    output logic stp_pullup_out,
    output logic data_pulldown_out,
    // analog and status
    input wire logic pll_locked_in,
    input wire logic fault_in,
    input wire upc_pkg::upc_rxcmd_t status_in,
    input wire logic low_power_in,
    output logic clock_enable_out,
    output logic pll_power_out,
    output logic low_power_exit_out,
    // control bits
    input wire logic protection_disable_bit_in,
    input wire logic internal_pump_enable_bit_in,
    input wire logic external_supply_enable_bit_in,
    input wire logic external_indicator_use_bit_in,
    input wire logic indicator_passthrough_bit_in,
    input wire logic function_reset_done_in,
    output logic charge_pump_out,
    output logic supply_switch_out,
    output logic supply_switch_oe_out,
    // decoded command toward the core
    output logic cmd_valid_out,
    output logic [1:0] cmd_class_out,
    output logic [5:0] cmd_payload_out,
    output logic cmd_ext_addr_out,
    output logic cmd_nopid_out,
    output logic [3:0] cmd_pid_out,
    output logic func_reset_out
);
    import upc_pkg::*;

    function automatic logic is_ext(input logic [7:0] b);
        return (b[7:6] == CLS_REGW || b[7:6] == CLS_REGR) &&
            b[5:0] == EXT_ADDR_CODE;
    endfunction

    // two-flop synchronisers; the first stage feeds only the second
    logic [4:0] meta, sync;
    logic [7:0] data_meta, data_s;
    logic hw_rst_s, cs_n_s, stp_s, lock_s, fault_s;
    assign {hw_rst_s, cs_n_s, stp_s, lock_s, fault_s} = sync;
    // reset loads the idle pin levels, so no false reset edge follows rstn
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            meta <= 5'h10;
            sync <= 5'h10;
            data_meta <= BUS_IDLE;
            data_s <= BUS_IDLE;
        end else begin
            meta <= {hw_reset_n_in, chip_select_n_in, stp_in,
                pll_locked_in, fault_in};
            sync <= meta;
            data_meta <= data_in;
            data_s <= data_meta;
        end
    end

    // status byte with the fault passed into the vbus valid field
    logic watch_fault;
    upc_rxcmd_t cur_rx, last_rx;
    logic [7:0] cur_byte;
    always_comb begin
        watch_fault = external_indicator_use_bit_in &
            indicator_passthrough_bit_in;
        cur_rx = status_in;
        if (watch_fault) begin
            cur_rx.vbus_state[A_VLD_BIT - 2] = fault_s;
        end
        cur_byte = cur_rx;
    end

    upc_state_t state;
    logic [REL_W-1:0] rel_cnt;
    logic in_reset, pll_done_seen, powered_up, cs_at_power;
    logic rx_pending, tx_accepted, need_next;
    logic [1:0] ready_sh, bus_fresh;
    assign in_reset = !hw_rst_s;
    // a change of fields raises a pending rxcmd; the send clears it,
    // and a change up to the send cycle goes out in that same rxcmd
    assign rx_pending = (cur_byte != last_rx);

    // main sequencer
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state <= ST_STARTUP;
            rel_cnt <= '0;
            last_rx <= '0;
            need_next <= 1'b0;
        end else if (in_reset) begin
            state <= ST_HW_RELEASE;
            rel_cnt <= '0;
            last_rx <= '0;
            need_next <= 1'b0;
        end else if (cs_n_s) begin
            // controller idles and commands are dropped
            if (state != ST_STARTUP && state != ST_WAIT_RESET &&
                state != ST_HW_RELEASE) begin
                state <= ST_IDLE;
            end
            need_next <= 1'b0;
        end else begin
            case (state)
                ST_STARTUP: begin
                    if (lock_s) begin
                        state <= ST_WAIT_RESET;
                    end
                end
                ST_WAIT_RESET: begin
                    if (function_reset_done_in) begin
                        state <= ST_IDLE;
                    end
                end
                ST_HW_RELEASE: begin
                    rel_cnt <= REL_W'(rel_cnt + 1'b1);
                    if (rel_cnt == RST_RELEASE_CYC - 3'h1) begin
                        state <= ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    // the rxcmd cuts in; a held command is taken after it
                    if (rx_pending) begin
                        state <= ST_TURN_IN;
                    end else if (bus_fresh[1] && data_s != BUS_IDLE) begin
                        state <= ST_CMD_DATA;
                        need_next <= (data_s[7:6] == CLS_XMIT) ||
                            is_ext(data_s);
                    end
                end
                ST_TURN_IN: state <= ST_RXCMD;
                ST_RXCMD: begin
                    last_rx <= cur_byte;
                    state <= ST_TURN_OUT;
                end
                ST_TURN_OUT: state <= ST_IDLE;
                ST_CMD_DATA: begin
                    // a short command waits for the idle byte, so the
                    // still synced command byte is not taken twice
                    if (need_next ? stp_s : data_s == BUS_IDLE) begin
                        state <= ST_IDLE;
                        need_next <= 1'b0;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end
    assign tx_accepted = (state == ST_IDLE) && !cs_n_s && !in_reset &&
        !(rx_pending) && bus_fresh[1] && data_s != BUS_IDLE;

    // synced data is stale for two cycles after the device owned the bus
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            bus_fresh <= 2'h0;
        end else if (dir_out) begin
            bus_fresh <= 2'h0;
        end else begin
            bus_fresh <= {bus_fresh[0], 1'b1};
        end
    end

    // ulpi pin drive
    logic next_dir;
    always_comb begin
        next_dir = (state == ST_STARTUP) || (state == ST_HW_RELEASE) ||
            (state == ST_TURN_IN) || (state == ST_RXCMD) || in_reset;
    end
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            dir_out <= 1'b1;
            nxt_out <= 1'b0;
            data_out <= BUS_IDLE;
            data_oe_out <= 1'b0;
            dir_oe_out <= 1'b0;
            nxt_oe_out <= 1'b0;
        end else begin
            dir_out <= next_dir;
            nxt_out <= tx_accepted ||
                (state == ST_CMD_DATA && need_next && !stp_s &&
                !in_reset);
            data_out <= (state == ST_RXCMD) ? cur_byte : BUS_IDLE;
            // bus driven only in the rxcmd cycle, the turn cycle is free
            data_oe_out <= (state == ST_RXCMD) && !cs_n_s;
            dir_oe_out <= !cs_n_s;
            nxt_oe_out <= !cs_n_s;
        end
    end

    // command decode handed to the core
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cmd_valid_out <= 1'b0;
            cmd_class_out <= CLS_IDLE;
            cmd_payload_out <= '0;
            cmd_ext_addr_out <= 1'b0;
            cmd_nopid_out <= 1'b0;
            cmd_pid_out <= 4'h0;
        end else begin
            cmd_valid_out <= tx_accepted;
            if (tx_accepted) begin
                cmd_class_out <= data_s[7:6];
                cmd_payload_out <= data_s[5:0];
                cmd_ext_addr_out <= is_ext(data_s);
                cmd_nopid_out <= data_s[7:6] == CLS_XMIT &&
                    data_s[5:0] == NOPID_CODE;
                cmd_pid_out <= data_s[3:0];
            end
        end
    end

    // protection, power, supply and low-power exit
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            stp_pullup_out <= 1'b1;
            data_pulldown_out <= 1'b0;
            charge_pump_out <= 1'b0;
            supply_switch_out <= 1'b0;
            supply_switch_oe_out <= 1'b0;
            clock_enable_out <= 1'b0;
            pll_power_out <= 1'b0;
            powered_up <= 1'b0;
            ready_sh <= 2'h0;
            low_power_exit_out <= 1'b0;
            func_reset_out <= 1'b0;
        end else begin
            stp_pullup_out <= !protection_disable_bit_in;
            data_pulldown_out <= stp_s && !protection_disable_bit_in &&
                !cs_n_s && !in_reset;
            charge_pump_out <= internal_pump_enable_bit_in &&
                !external_supply_enable_bit_in;
            supply_switch_out <= 1'b0;
            supply_switch_oe_out <= external_supply_enable_bit_in;
            clock_enable_out <= lock_s && state != ST_STARTUP;
            // chip select is read only once the synchroniser holds it
            ready_sh <= {ready_sh[0], 1'b1};
            if (!powered_up && ready_sh[1]) begin
                powered_up <= 1'b1;
                pll_power_out <= !cs_n_s;
            end else if (powered_up && !cs_n_s) begin
                pll_power_out <= 1'b1;
            end
            // stp still leaves low power even when deselected
            low_power_exit_out <= low_power_in && stp_s;
            func_reset_out <= state == ST_WAIT_RESET;
        end
    end

    dir_hold_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        state == ST_WAIT_RESET |=> !dir_out)
        else $error("dir not low while waiting for reset");
    reset_dir_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        in_reset |=> dir_out)
        else $error("dir low during hardware reset");
    nxt_in_rx_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        dir_out |-> !nxt_out)
        else $error("nxt high with dir");
    cs_tristate_a: assert property (@(posedge sys_clk_in)
        disable iff (!rstn_in) cs_n_s |=> !dir_oe_out && !data_oe_out)
        else $error("pins driven while deselected");
    turn_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        state == ST_TURN_IN |=> state == ST_RXCMD || in_reset || cs_n_s)
        else $error("turnaround skipped");
    pump_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        external_supply_enable_bit_in ##1 external_supply_enable_bit_in
        |-> !charge_pump_out && supply_switch_oe_out)
        else $error("supply selection wrong");
    release_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        $rose(hw_rst_s) && !cs_n_s ##1 !cs_n_s [*4] |=> !dir_out)
        else $error("dir late after reset release");
    rx_byte_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        state == ST_RXCMD && !cs_n_s && !in_reset
        |=> data_oe_out && data_out == $past(cur_byte))
        else $error("rxcmd byte wrong");
    cov_rx_c: cover property (@(posedge sys_clk_in) state == ST_RXCMD);
    cov_tx_c: cover property (@(posedge sys_clk_in) cmd_valid_out);
    cov_ext_c: cover property (@(posedge sys_clk_in) cmd_ext_addr_out);
endmodule

// File: testbench/tb.sv
// self-checking bench for the ulpi interface control block
`timescale 1ns/1ps
module tb;
    import upc_pkg::*;
    logic clk = 0, rstn = 0, hw_n = 1, cs_n = 0, pll = 0, fault = 0, lp = 0;
    logic pdis = 0, pump = 0, ext = 0, use_i = 0, pass = 0, done = 0;
    logic go = 0, stpf = 0, lclk = 0, busy, stp, d_oe, dir, dir_oe, nxt;
    logic nxt_oe, pu, pd, ce, pllp, lpx, cp, sw, sw_oe, cv, cext, cnop, frst;
    logic [1:0] ccls;
    logic [5:0] cpay, cap_x;
    logic [3:0] cpid;
    logic [7:0] ldata, bus, dout, cmd = 0, cap_b = 0, cap_c = 0;
    logic [7:0] corner [4] = '{8'h40, 8'h4d, 8'haf, 8'hef};
    upc_rxcmd_t st = '0;
    int miscompares = 0, checks_done = 0, ncmd = 0, nrx = 0, nxt_bad = 0;
    always #50 clk = ~clk;
    initial #137 forever #400 lclk = ~lclk;
    // nobody drives in turnaround: a toggling pattern, never a stale value
    assign bus = d_oe ? dout : (dir ? {4{clk, ~clk}} : ldata);
    upc_ulpi_ctrl u_dut (.sys_clk_in(clk), .rstn_in(rstn),
        .hw_reset_n_in(hw_n), .chip_select_n_in(cs_n), .stp_in(stp),
        .data_in(bus), .data_out(dout), .data_oe_out(d_oe), .dir_out(dir),
        .dir_oe_out(dir_oe), .nxt_out(nxt), .nxt_oe_out(nxt_oe),
        .stp_pullup_out(pu), .data_pulldown_out(pd), .pll_locked_in(pll),
        .fault_in(fault), .status_in(st), .low_power_in(lp),
        .clock_enable_out(ce), .pll_power_out(pllp),
        .low_power_exit_out(lpx), .protection_disable_bit_in(pdis),
        .internal_pump_enable_bit_in(pump),
        .external_supply_enable_bit_in(ext),
        .external_indicator_use_bit_in(use_i),
        .indicator_passthrough_bit_in(pass),
        .function_reset_done_in(done), .charge_pump_out(cp),
        .supply_switch_out(sw), .supply_switch_oe_out(sw_oe),
        .cmd_valid_out(cv), .cmd_class_out(ccls), .cmd_payload_out(cpay),
        .cmd_ext_addr_out(cext), .cmd_nopid_out(cnop),
        .cmd_pid_out(cpid), .func_reset_out(frst));
    upc_link_model u_link (.sys_clk_in(clk), .link_clk_in(lclk),
        .hw_reset_n_in(hw_n), .dir_in(dir), .nxt_in(nxt), .data_out(ldata),
        .stp_out(stp), .go_in(go), .cmd_in(cmd), .stp_force_in(stpf),
        .busy_out(busy));
    always @(posedge clk) begin
        if (cv) begin
            ncmd <= ncmd + 1;
            cap_c <= {ccls, cpay};
            cap_x <= {cext, cnop, cpid};
        end
        if (d_oe) begin
            nrx <= nrx + 1;
            cap_b <= dout;
        end
        if (dir && dir_oe && nxt)
            nxt_bad <= nxt_bad + 1;
    end
    task automatic chk(input string nm, input logic [7:0] e, g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    function automatic logic [7:0] exp_rx(upc_rxcmd_t s, logic f, u, p);
        logic [7:0] b;
        b = s;
        if (u && p)
            b[A_VLD_BIT] = f;
        return b;
    endfunction
    task automatic issue(input logic [7:0] c);
        @(posedge clk) begin
            cmd <= c;
            go <= 1'b1;
        end
        @(posedge clk) go <= 1'b0;
        cyc(1);
        for (int i = 0; i < 150 && busy; i++)
            cyc(1);
    endtask
    task automatic send(input logic [7:0] c);
        int n0;
        logic [1:0] k;
        n0 = ncmd;
        k = c[7:6];
        issue(c);
        chk("cmd count", 8'(n0 + 1), 8'(ncmd));
        chk("class", 8'(k), 8'(cap_c[7:6]));
        chk("payload", 8'(c[5:0]), 8'(cap_c[5:0]));
        chk("ext", 8'(k[1] && c[5:0] == EXT_ADDR_CODE), 8'(cap_x[5]));
        chk("nopid", 8'(k == CLS_XMIT && !c[5:0]), 8'(cap_x[4]));
        if (k == CLS_XMIT)
            chk("pid", 8'(c[3:0]), 8'(cap_x[3:0]));
    endtask
    initial begin
        #3000000;
        miscompares++;
        wrap_up();
    end
    initial begin
        int n0;
        logic [7:0] c;
        void'($urandom(32'h2058af88));
        cyc(5);
        @(posedge clk) rstn <= 1'b1;
        cyc(2);
        chk("dir before lock", 8'h1, 8'(dir));
        chk("stp pullup", 8'h1, 8'(pu));
        @(posedge clk) pll <= 1'b1;
        cyc(10);
        chk("pll power", 8'h1, 8'(pllp));
        chk("clock on", 8'h1, 8'(ce));
        chk("dir after lock", 8'h0, 8'(dir));
        chk("wait reset", 8'h1, 8'(frst));
        @(posedge clk) st <= upc_rxcmd_t'(8'h15);
        cyc(10);
        chk("dir held", 8'h0, 8'(dir));
        @(posedge clk) done <= 1'b1;
        cyc(20);
        chk("reset done", 8'h0, 8'(frst));
        $display("test startup done");
        @(posedge clk) stpf <= 1'b1;
        cyc(5);
        chk("pulldown", 8'h1, 8'(pd));
        @(posedge clk) pdis <= 1'b1;
        cyc(5);
        chk("pulldown off", 8'h0, 8'(pd));
        chk("pullup off", 8'h0, 8'(pu));
        @(posedge clk) begin
            stpf <= 1'b0;
            pdis <= 1'b0;
        end
        for (int i = 0; i < 4; i++) begin
            @(posedge clk) {pump, ext} <= i[1:0];
            cyc(3);
            chk("pump", 8'(i == 2), 8'(cp));
            chk("switch en", 8'(i[0]), 8'(sw_oe));
            chk("switch low", 8'h0, 8'(sw));
        end
        $display("test protection and supply done");
        for (int i = 0; i < 12; i++) begin
            n0 = nrx;
            @(posedge clk) begin
                st <= st ^ (8'($urandom) | 8'h01);
                {pass, use_i, fault} <= i[2:0];
            end
            cyc(14);
            chk("rxcmd sent", 8'h1, 8'(nrx > n0));
            chk("rxcmd", exp_rx(st, fault, use_i, pass), cap_b);
        end
        for (int i = 1; i >= 0; i--) begin
            @(posedge clk) {use_i, pass} <= {1'b1, i[0]};
            cyc(14);
            n0 = nrx;
            @(posedge clk) fault <= ~fault;
            cyc(14);
            chk("fault rxcmd", 8'(i), 8'(nrx - n0));
        end
        $display("test rxcmd done");
        foreach (corner[j])
            send(corner[j]);
        for (int i = 0; i < 12; i++) begin
            c = {2'($urandom_range(1, 3)), 6'($urandom)};
            if (c[7:6] == CLS_XMIT)
                c[5:4] = PID_HI_ZERO;
            send(c);
        end
        chk("nxt under dir", 8'h0, 8'(nxt_bad));
        $display("test commands done");
        @(posedge clk) begin
            cs_n <= 1'b1;
            stpf <= 1'b1;
            lp <= 1'b1;
        end
        cyc(6);
        chk("pins off", 8'h0, 8'({d_oe, dir_oe, nxt_oe}));
        chk("pulldown cs", 8'h0, 8'(pd));
        chk("stp exit", 8'h1, 8'(lpx));
        chk("pll kept", 8'h1, 8'(pllp));
        n0 = ncmd;
        @(posedge clk) stpf <= 1'b0;
        issue(8'h81);
        chk("cmd ignored", 8'h0, 8'(ncmd - n0));
        @(posedge clk) begin
            cs_n <= 1'b0;
            lp <= 1'b0;
        end
        cyc(5);
        $display("test chip select done");
        @(posedge clk) hw_n <= 1'b0;
        cyc(5);
        chk("dir hw reset", 8'h1, 8'(dir));
        @(posedge clk) hw_n <= 1'b1;
        cyc(3);
        chk("dir early", 8'h1, 8'(dir));
        cyc(4);
        chk("dir release", 8'h0, 8'(dir));
        $display("test hardware reset done");
        wrap_up();
    end
endmodule

// File: testbench/upc_link_model.sv
// link controller model on the ulpi side of the bench
`timescale 1ns/1ps
module upc_link_model (
    // clocks
    input wire logic sys_clk_in,
    input wire logic link_clk_in,
    // ulpi pins
    input wire logic hw_reset_n_in,
    input wire logic dir_in,
    input wire logic nxt_in,
    output logic [7:0] data_out,
    output logic stp_out,
    // bench control
    input wire logic go_in,
    input wire logic [7:0] cmd_in,
    input wire logic stp_force_in,
    output logic busy_out
);
    logic [2:0] lk = 3'h0;
    logic [1:0] ph = 2'h0;
    logic [6:0] wt = 7'h0;
    logic stp_q = 1'b0;
    initial data_out = 8'h00;
    initial busy_out = 1'b0;
    assign stp_out = (stp_q | stp_force_in) & hw_reset_n_in;
    always @(posedge sys_clk_in) begin
        lk <= {lk[1:0], link_clk_in};
        stp_q <= 1'b0;
        if (!hw_reset_n_in) begin
            data_out <= 8'h00;
            ph <= 2'h0;
            busy_out <= 1'b0;
        end else if (ph == 2'h0) begin
            data_out <= 8'h00;
            if (go_in)
                busy_out <= 1'b1;
            // start on a link clock edge, which comes every eight sys_clk_in cycles at a fixed phase
            if ((go_in || busy_out) && lk[1] && !lk[2]) begin
                data_out <= cmd_in;
                ph <= 2'h1;
                wt <= 7'h0;
            end
        end else if (ph == 2'h1) begin
            wt <= wt + 7'h1;
            // an rxcmd may cut in; the command is simply held meanwhile
            if (nxt_in && !dir_in) begin
                data_out <= ~cmd_in;
                ph <= 2'h2;
            end else if (wt == 7'h5f) begin
                // a refused command is dropped, as a real link gives up
                data_out <= 8'h00;
                ph <= 2'h0;
                busy_out <= 1'b0;
            end
        end else begin
            data_out <= 8'h00;
            stp_q <= 1'b1;
            ph <= 2'h0;
            busy_out <= 1'b0;
        end
    end
endmodule
